// >>> design/boot_loader_pkg.sv
/*
 * boot mode loader package: mode codes, states, load-sequence constants.
 * assumes the loader top and its word store are its only users.
 */
package boot_loader_pkg;

	// boot mode: {port select, strap high, strap low}
	typedef enum logic [2:0] {
		MODE_EXT16   = 3'h0,
		MODE_EPROM   = 3'h1,
		MODE_HOST    = 3'h2,
		MODE_RSVD    = 3'h3,
		MODE_EXT8    = 3'h4,
		MODE_UART    = 3'h5,
		MODE_SPI_SML = 3'h6,
		MODE_SPI_BIG = 3'h7
	} boot_mode_t;

	typedef enum logic [6:0] {
		ST_RESET = 7'h01,
		ST_LATCH = 7'h02,
		ST_BRANCH = 7'h04,
		ST_LOAD = 7'h08,
		ST_WAIT = 7'h10,
		ST_DONE = 7'h20,
		ST_HALT = 7'h40
	} load_state_t;

	localparam logic [23:0] BOOT_ROM_ADDR    = 24'hFF0000;
	localparam logic [23:0] BOOT_STREAM_ADDR = 24'h010000;
	localparam logic [23:0] EXT8_PAGE1_ADDR  = 24'h010000;
	localparam logic [23:0] INT_START_ADDR   = 24'h000000;
	localparam logic [7:0]  CLKMUL_NOBOOT    = 8'h80;   // 128
	localparam logic [7:0]  CLKMUL_EPROM     = 8'h20;   // 32
	localparam logic [2:0]  READ_WAITS       = 3'h7;
	localparam logic [4:0]  PROG_RSV_WORDS   = 5'h10;   // 16
	localparam logic [8:0]  DATA_RSV_WORDS   = 9'h110;  // 272
	localparam logic [7:0]  UART_FILL_CHAR   = 8'hFF;
	localparam logic [3:0]  UART_FRAME_BITS  = 4'hA;    // start, 8 data, stop
	localparam logic [7:0]  SPI_READ_CMD     = 8'h03;   // arbitrary read opcode
	localparam logic [15:0] SPI_START_ADDR   = 16'h0000;
	localparam logic [4:0]  SPI_ADDR_SML     = 5'h0C;   // 12-bit address
	localparam logic [4:0]  SPI_ADDR_BIG     = 5'h10;   // 16-bit address
	localparam logic [6:0]  SPI_BAUD_DIV     = 7'h3C;   // 60 decimal
	localparam logic        SPI_CPHA         = 1'b1;
	localparam logic        SPI_CPOL         = 1'b1;
	localparam logic [3:0]  SPI_WORD_BITS    = 4'h8;
	localparam logic        SPI_MSB_FIRST    = 1'b1;
	localparam logic [1:0]  SYNC_LAST        = 2'h2;

endpackage

// >>> design/word_pack.sv
/*
 * word packer: gathers 8- or 16-bit external words into 24-bit internal words.
 * assumes the caller holds wide_en stable for a whole stream.
 */
`timescale 1ns/100ps
module word_pack
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        in_valid,
	input  wire logic [15:0] in_data,
	input  wire logic        wide_en,
	output logic             out_valid,
	output logic      [23:0] out_word
);

	logic [23:0] acc_q;
	logic [1:0]  cnt_q;
	logic [1:0]  cnt_d;
	logic [23:0] acc_d;
	logic        full_w;

	// 8-bit: three bytes per word; 16-bit: low half then the second word's low byte as the high byte
	assign full_w = wide_en ? (cnt_q == 2'h1) : (cnt_q == 2'h2);
	assign acc_d  = wide_en ? ((cnt_q == 2'h0) ? {8'h00, in_data} : {in_data[7:0], acc_q[15:0]})
	                        : {acc_q[15:0], in_data[7:0]};
	assign cnt_d  = full_w ? 2'h0 : cnt_q + 2'h1;

	// register output keeps the packed word glitch free for the store
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			acc_q     <= 24'h000000;
			cnt_q     <= 2'h0;
			out_valid <= 1'b0;
			out_word  <= 24'h000000;
		end
		else
		begin
			out_valid <= in_valid && full_w;
			if (in_valid)
			begin
				acc_q <= acc_d;
				cnt_q <= cnt_d;
				if (full_w)
					out_word <= acc_d;
			end
		end
	end

endmodule

// >>> design/boot_mode_loader.sv
/*
 * boot mode loader: latches straps at reset, chooses the loader, sets up the
 * external port, serial port and uart for the chosen sequence.
 * assumes straps and host semaphore are asynchronous pins; rest on CLK.
 */
// What this block does
// - latch straps at reset, combine config bits
// - port low: ext16, eprom, host, reserved
// - port high: ext8, uart, small spi, big spi
// - ext16 stream at 0x10000 into 24-bit words
// - no-boot modes: multiplier 128, seven waits
// - eprom: 0x10000, multiplier 32, seven waits
// - host: set semaphore, hold core till cleared
// - semaphore clear: vectors page 0, start 0x0000
// - host writes memory, then clears semaphore
// - reserve top 16 program, 272 data words
// - ext8 runs from page 1, packed words
// - uart sends 0xFF until block start seen
// - spi select on flag pin, read at 0x00
// - small eprom 12-bit, big 16-bit address
// - spi divisor 60, cpha1 cpol1, 8-bit msb
// - release without bus request branches to boot rom
`timescale 1ns/100ps
module boot_mode_loader
(
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        PORT_SELECT_STRAP,
	input  wire logic        BOOT_STRAP_HIGH,
	input  wire logic        BOOT_STRAP_LOW,
	input  wire logic [2:0]  RESET_CONFIG,
	input  wire logic        BUS_REQUEST,
	input  wire logic        HOST_SEM_CLEAR,
	input  wire logic        UART_BLOCK_START,
	input  wire logic        LOAD_DONE,
	input  wire logic        EXT_VALID,
	input  wire logic [15:0] EXT_DATA,
	input  wire logic        EXT_WIDE,
	output logic      [2:0]  BOOT_MODE,
	output logic      [2:0]  BOOT_CONFIG,
	output logic      [23:0] FETCH_ADDR,
	output logic      [7:0]  CLOCK_MULT,
	output logic      [2:0]  READ_WAIT,
	output logic             CORE_HOLD,
	output logic             HOST_SEMAPHORE,
	output logic             VECTORS_PAGE0,
	output logic      [4:0]  PROG_RESERVED,
	output logic      [8:0]  DATA_RESERVED,
	output logic             UART_TX_REQ,
	output logic      [7:0]  UART_TX_CHAR,
	output logic      [3:0]  UART_FRAME,
	output logic             SERIAL_BOOT_SLAVE_SELECT,
	output logic             FLAG_PIN_TWO_TAKEN,
	output logic      [7:0]  SPI_CMD,
	output logic      [15:0] SPI_ADDR,
	output logic      [4:0]  SPI_ADDR_BITS,
	output logic      [6:0]  SERIAL_BAUD_DIVISOR,
	output logic             SPI_PHASE,
	output logic             SPI_POLARITY,
	output logic      [3:0]  SPI_WORD,
	output logic             SPI_MSB,
	output logic             WORD_VALID,
	output logic      [23:0] WORD_DATA,
	output logic             LOAD_ACTIVE
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three flops, a change counts once two and three agree
	logic [2:0] sync0_q, sync1_q, sync2_q, hsync_q;
	logic [2:0] pins_w;
	logic [2:0] pin_clean_q;
	logic       sem_clear_q;
	assign pins_w = {PORT_SELECT_STRAP, BOOT_STRAP_HIGH, BOOT_STRAP_LOW};

	always_ff @(posedge CLK)
	begin
		sync0_q <= pins_w;
		sync1_q <= sync0_q;
		sync2_q <= sync1_q;
		hsync_q <= {hsync_q[1:0], HOST_SEM_CLEAR};
	end

	// filtered levels; straps keep filtering through reset so the code is ready at release
	always_ff @(posedge CLK)
	begin
		if (sync1_q == sync2_q)
			pin_clean_q <= sync2_q;
		if (!RESETN)
			sem_clear_q <= 1'b0;
		else if (hsync_q[1] == hsync_q[2])
			sem_clear_q <= hsync_q[2];
	end

	////////////////////////////////////////////////////////////////////////
	// load sequencer
	boot_loader_pkg::load_state_t state_q, state_d;
	boot_loader_pkg::boot_mode_t  mode_w;
	logic [2:0]                   mode_q;
	logic                         no_boot_w, is_host_w, is_uart_w, is_spi_w, is_rsvd_w;
	logic                         uart_seen_q;

	// straps are held low-going during reset, so the code keeps tracking them
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			mode_q <= pin_clean_q;
		else if (state_q == boot_loader_pkg::ST_LATCH)
			mode_q <= pin_clean_q;
	end

	assign mode_w    = boot_loader_pkg::boot_mode_t'(mode_q);
	assign no_boot_w = (mode_w == boot_loader_pkg::MODE_EXT16) || (mode_w == boot_loader_pkg::MODE_EXT8);
	assign is_host_w = (mode_w == boot_loader_pkg::MODE_HOST);
	assign is_uart_w = (mode_w == boot_loader_pkg::MODE_UART);
	assign is_spi_w  = (mode_w == boot_loader_pkg::MODE_SPI_SML) || (mode_w == boot_loader_pkg::MODE_SPI_BIG);
	assign is_rsvd_w = (mode_w == boot_loader_pkg::MODE_RSVD);

	// next state; bus request simply holds the branch off until released
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			boot_loader_pkg::ST_RESET:  state_d = boot_loader_pkg::ST_LATCH;
			boot_loader_pkg::ST_LATCH:  state_d = boot_loader_pkg::ST_BRANCH;
			boot_loader_pkg::ST_BRANCH:
				if (!BUS_REQUEST)
					state_d = is_rsvd_w ? boot_loader_pkg::ST_HALT
					        : (is_host_w ? boot_loader_pkg::ST_WAIT : boot_loader_pkg::ST_LOAD);
			boot_loader_pkg::ST_LOAD:   if (LOAD_DONE) state_d = boot_loader_pkg::ST_DONE;
			boot_loader_pkg::ST_WAIT:   if (sem_clear_q) state_d = boot_loader_pkg::ST_DONE;
			boot_loader_pkg::ST_DONE:   state_d = boot_loader_pkg::ST_DONE;
			boot_loader_pkg::ST_HALT:   state_d = boot_loader_pkg::ST_HALT;
			default:                    state_d = boot_loader_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			state_q <= boot_loader_pkg::ST_RESET;
		else
			state_q <= state_d;
	end

	// uart fill stops for good once the first block start is seen
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			uart_seen_q <= 1'b0;
		else if (UART_BLOCK_START && state_q == boot_loader_pkg::ST_LOAD)
			uart_seen_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// packing of external data into 24-bit words
	logic        pk_valid;
	logic [23:0] pk_word;
	logic        pk_in_w;

	// ext16 always wide; eprom and ext8 follow the width pin
	assign pk_in_w = EXT_VALID && (state_q == boot_loader_pkg::ST_LOAD) && (no_boot_w ||
	                 mode_w == boot_loader_pkg::MODE_EPROM);

	word_pack u_pack
	(
		.clk       (CLK),
		.resetn    (RESETN),
		.in_valid  (pk_in_w),
		.in_data   (EXT_DATA),
		.wide_en   (mode_w == boot_loader_pkg::MODE_EXT16 ? 1'b1 : EXT_WIDE),
		.out_valid (pk_valid),
		.out_word  (pk_word)
	);

	////////////////////////////////////////////////////////////////////////
	// decoded port setup
	logic        active_w, loading_w, rom_w;
	logic [23:0] addr_w;
	assign loading_w = (state_q == boot_loader_pkg::ST_LOAD);
	assign active_w  = loading_w || (state_q == boot_loader_pkg::ST_WAIT);
	assign rom_w     = is_host_w || is_uart_w || is_spi_w;
	assign addr_w    = (state_q == boot_loader_pkg::ST_BRANCH) ? boot_loader_pkg::BOOT_ROM_ADDR
	                 : (state_q == boot_loader_pkg::ST_DONE && is_host_w) ? boot_loader_pkg::INT_START_ADDR
	                 : (mode_w == boot_loader_pkg::MODE_EXT8) ? boot_loader_pkg::EXT8_PAGE1_ADDR
	                 : boot_loader_pkg::BOOT_STREAM_ADDR;

	// all outputs registered
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			BOOT_MODE <= 3'h0; BOOT_CONFIG <= 3'h0; FETCH_ADDR <= 24'h000000;
			CLOCK_MULT <= 8'h00; READ_WAIT <= 3'h0; CORE_HOLD <= 1'b1;
			HOST_SEMAPHORE <= 1'b0; VECTORS_PAGE0 <= 1'b0;
			PROG_RESERVED <= 5'h00; DATA_RESERVED <= 9'h000;
			UART_TX_REQ <= 1'b0; UART_TX_CHAR <= 8'h00; UART_FRAME <= 4'h0;
			SERIAL_BOOT_SLAVE_SELECT <= 1'b0; FLAG_PIN_TWO_TAKEN <= 1'b0;
			SPI_CMD <= 8'h00; SPI_ADDR <= 16'h0000; SPI_ADDR_BITS <= 5'h00;
			SERIAL_BAUD_DIVISOR <= 7'h00; SPI_PHASE <= 1'b0; SPI_POLARITY <= 1'b0;
			SPI_WORD <= 4'h0; SPI_MSB <= 1'b0;
			WORD_VALID <= 1'b0; WORD_DATA <= 24'h000000; LOAD_ACTIVE <= 1'b0;
		end
		else
		begin
			BOOT_MODE   <= mode_q;
			BOOT_CONFIG <= RESET_CONFIG;
			FETCH_ADDR  <= addr_w;
			CLOCK_MULT  <= no_boot_w ? boot_loader_pkg::CLKMUL_NOBOOT : boot_loader_pkg::CLKMUL_EPROM;
			READ_WAIT   <= boot_loader_pkg::READ_WAITS;
			CORE_HOLD   <= state_q != boot_loader_pkg::ST_DONE;
			HOST_SEMAPHORE <= is_host_w && state_q == boot_loader_pkg::ST_WAIT;
			VECTORS_PAGE0  <= is_host_w && state_q == boot_loader_pkg::ST_DONE;
			PROG_RESERVED  <= rom_w ? boot_loader_pkg::PROG_RSV_WORDS : 5'h00;
			DATA_RESERVED  <= rom_w ? boot_loader_pkg::DATA_RSV_WORDS : 9'h000;
			UART_TX_REQ    <= is_uart_w && loading_w && !uart_seen_q && !UART_BLOCK_START;
			UART_TX_CHAR   <= boot_loader_pkg::UART_FILL_CHAR;
			UART_FRAME     <= boot_loader_pkg::UART_FRAME_BITS;
			SERIAL_BOOT_SLAVE_SELECT <= is_spi_w && loading_w;
			FLAG_PIN_TWO_TAKEN <= is_spi_w && active_w;
			SPI_CMD  <= boot_loader_pkg::SPI_READ_CMD;
			SPI_ADDR <= boot_loader_pkg::SPI_START_ADDR;
			SPI_ADDR_BITS <= (mode_w == boot_loader_pkg::MODE_SPI_SML) ? boot_loader_pkg::SPI_ADDR_SML
			               : boot_loader_pkg::SPI_ADDR_BIG;
			SERIAL_BAUD_DIVISOR <= boot_loader_pkg::SPI_BAUD_DIV;
			SPI_PHASE    <= boot_loader_pkg::SPI_CPHA;
			SPI_POLARITY <= boot_loader_pkg::SPI_CPOL;
			SPI_WORD     <= boot_loader_pkg::SPI_WORD_BITS;
			SPI_MSB      <= boot_loader_pkg::SPI_MSB_FIRST;
			WORD_VALID   <= pk_valid;
			WORD_DATA    <= pk_word;
			LOAD_ACTIVE  <= active_w;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_hold_till_clear;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == boot_loader_pkg::ST_WAIT && !sem_clear_q) |=> ##1 CORE_HOLD;
	endproperty
	a_hold_till_clear: assert property (p_hold_till_clear) else $error("core released early");

	property p_vectors;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == boot_loader_pkg::ST_WAIT && sem_clear_q) |=> ##1 (VECTORS_PAGE0 && !CORE_HOLD);
	endproperty
	a_vectors: assert property (p_vectors) else $error("no start after semaphore");

	property p_branch;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == boot_loader_pkg::ST_BRANCH) |=> (FETCH_ADDR == 24'hFF0000);
	endproperty
	a_branch: assert property (p_branch) else $error("boot rom not addressed");

	property p_bus_hold;
		@(posedge CLK) disable iff (!RESETN)
		(state_q == boot_loader_pkg::ST_BRANCH && BUS_REQUEST) |=> (state_q == boot_loader_pkg::ST_BRANCH);
	endproperty
	a_bus_hold: assert property (p_bus_hold) else $error("branch under bus request");

	property p_rsvd;
		@(posedge CLK) disable iff (!RESETN)
		is_rsvd_w |-> !active_w;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code loading");

	property p_mode_stable;
		@(posedge CLK) disable iff (!RESETN)
		(active_w && $past(active_w)) |-> $stable(mode_q);
	endproperty
	a_mode_stable: assert property (p_mode_stable) else $error("mode changed in load");

	property p_mult;
		@(posedge CLK) disable iff (!RESETN)
		(active_w && no_boot_w) |=> (CLOCK_MULT == 8'h80 && READ_WAIT == 3'h7);
	endproperty
	a_mult: assert property (p_mult) else $error("no-boot port setup wrong");

	property p_eprom;
		@(posedge CLK) disable iff (!RESETN)
		(active_w && mode_w == boot_loader_pkg::MODE_EPROM) |=> (CLOCK_MULT == 8'h20 && FETCH_ADDR == 24'h010000);
	endproperty
	a_eprom: assert property (p_eprom) else $error("eprom setup wrong");

	property p_uart_stop;
		@(posedge CLK) disable iff (!RESETN)
		uart_seen_q |=> !UART_TX_REQ;
	endproperty
	a_uart_stop: assert property (p_uart_stop) else $error("fill after block start");

	property p_spi_sel;
		@(posedge CLK) disable iff (!RESETN)
		(loading_w && is_spi_w) |=> (SERIAL_BOOT_SLAVE_SELECT && SERIAL_BAUD_DIVISOR == 7'h3C);
	endproperty
	a_spi_sel: assert property (p_spi_sel) else $error("spi select or divisor wrong");

endmodule

// >>> dv/boot_far_side.sv
/*
 * far side of the loader: a host that releases the semaphore, a uart host
 * and an external boot memory that streams words.
 * assumes the loader outputs are registered on the same clock as this model.
 */
`timescale 1ns/100ps
module boot_far_side
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        host_en,
	input  wire logic        uart_en,
	input  wire logic        stream_en,
	input  wire logic        slow,
	input  wire logic        sem_set,
	input  wire logic        tx_req,
	input  wire logic        load_active,
	output logic             sem_clear,
	output logic             block_start,
	output logic             ext_valid,
	output logic      [15:0] ext_data
);
	logic [3:0] dly_q;
	logic [2:0] idx_q;
	logic       gap_q;

	////////////////////////////////////////////////////////////////////////
	// host and uart agents answer late on purpose, so the hold-off is seen
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			dly_q <= 4'h0;
			sem_clear <= 1'b0;
			block_start <= 1'b0;
		end
		else
		begin
			if ((host_en && sem_set) || (uart_en && tx_req))
				dly_q <= dly_q + 4'h1;
			if (host_en && dly_q == 4'h6)
				sem_clear <= 1'b1;
			block_start <= uart_en && dly_q == 4'h6;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory streams six words; idle data is scrambled, never the last value
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			idx_q <= 3'h0;
			gap_q <= 1'b0;
			ext_valid <= 1'b0;
			ext_data <= 16'hFFFF;
		end
		else if (load_active && stream_en && idx_q < 3'h6 && !(slow && gap_q))
		begin
			ext_valid <= 1'b1;
			ext_data <= {8'hC0 + 8'(idx_q), 8'hA0 + 8'(idx_q)};
			idx_q <= idx_q + 3'h1;
			gap_q <= 1'b1;
		end
		else
		begin
			ext_valid <= 1'b0;
			ext_data <= ~ext_data;
			gap_q <= 1'b0;
		end
	end
endmodule

// >>> dv/test_boot_mode_loader.sv
/*
 * self-checking bench for the boot mode loader: every strap code, host,
 * uart, serial and external memory sequences, bus request hold-off.
 * assumes the far side model drives the semaphore, block start and stream.
 */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
`define WAITFOR(sig, val) begin int n; n = 0; while ((sig) !== (val) && n < 60) \
	begin @(negedge CLK); n++; end if ((sig) !== (val)) begin err_count++; conclude(); end end
module test_boot_mode_loader;
	logic CLK, RESETN, PORT_SELECT_STRAP, BOOT_STRAP_HIGH, BOOT_STRAP_LOW, BUS_REQUEST;
	logic HOST_SEM_CLEAR, UART_BLOCK_START, LOAD_DONE, EXT_VALID, EXT_WIDE, CORE_HOLD;
	logic HOST_SEMAPHORE, VECTORS_PAGE0, UART_TX_REQ, SERIAL_BOOT_SLAVE_SELECT, FLAG_PIN_TWO_TAKEN;
	logic SPI_PHASE, SPI_POLARITY, SPI_MSB, WORD_VALID, LOAD_ACTIVE;
	logic host_en, uart_en, stream_en, slow;
	logic [2:0] RESET_CONFIG, BOOT_MODE, BOOT_CONFIG, READ_WAIT;
	logic [15:0] EXT_DATA, SPI_ADDR;
	logic [23:0] FETCH_ADDR, WORD_DATA;
	logic [7:0] CLOCK_MULT, UART_TX_CHAR, SPI_CMD;
	logic [4:0] PROG_RESERVED, SPI_ADDR_BITS;
	logic [8:0] DATA_RESERVED;
	logic [3:0] UART_FRAME, SPI_WORD;
	logic [6:0] SERIAL_BAUD_DIVISOR;
	logic [23:0] words[4];
	int wcnt, err_count, tests_run;

	boot_mode_loader i_boot_mode_loader (.*);
	boot_far_side i_boot_far_side (.clk(CLK), .resetn(RESETN), .host_en(host_en), .uart_en(uart_en),
		.stream_en(stream_en), .slow(slow), .sem_set(HOST_SEMAPHORE), .tx_req(UART_TX_REQ),
		.load_active(LOAD_ACTIVE), .sem_clear(HOST_SEM_CLEAR), .block_start(UART_BLOCK_START),
		.ext_valid(EXT_VALID), .ext_data(EXT_DATA));

	////////////////////////////////////////////////////////////////////////
	// clock, and a record of the first four packed words
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK)
	begin
		if (!RESETN)
			wcnt <= 0;
		else if (WORD_VALID === 1'b1 && wcnt < 4)
		begin
			words[wcnt] <= WORD_DATA;
			wcnt <= wcnt + 1;
		end
	end

	task automatic conclude();
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// straps are only valid while reset is low; config bits vary with them
	task automatic rst(input logic [2:0] m);
		@(negedge CLK);
		RESETN = 1'b0;
		{PORT_SELECT_STRAP, BOOT_STRAP_HIGH, BOOT_STRAP_LOW} = m;
		RESET_CONFIG = ~m;
		repeat (8) @(negedge CLK);
		RESETN = 1'b1;
		repeat (12) @(negedge CLK);
	endtask

	////////////////////////////////////////////////////////////////////////
	// each strap code and the set-up that it must produce
	task automatic all_modes();
		logic [2:0] m;
		logic rsv;
		for (int i = 0; i < 8; i++)
		begin
			m = 3'(i);
			rst(m);
			rsv = m inside {3'h2, 3'h5, 3'h6, 3'h7};
			`CHK("mode", m, BOOT_MODE)
			`CHK("config", ~m, BOOT_CONFIG)
			`CHK("prog rsv", rsv ? 5'h10 : 5'h00, PROG_RESERVED)
			`CHK("data rsv", rsv ? 9'h110 : 9'h000, DATA_RESERVED)
			`CHK("active", m != 3'h3, LOAD_ACTIVE)
			if (m inside {3'h0, 3'h1, 3'h4})
			begin
				`CHK("mult", m == 3'h1 ? 8'h20 : 8'h80, CLOCK_MULT)
				`CHK("waits", 3'h7, READ_WAIT)
				`CHK("fetch", 24'h010000, FETCH_ADDR)
			end
			if (m == 3'h2)
				`CHK("sem", 2'h3, {HOST_SEMAPHORE, CORE_HOLD})
			if (m == 3'h3)
				`CHK("rsvd", 3'h4, {CORE_HOLD, LOAD_ACTIVE, HOST_SEMAPHORE})
			if (m == 3'h5)
				`CHK("uart", 13'h1FFA, {UART_TX_REQ, UART_TX_CHAR, UART_FRAME})
			if (m[2:1] == 2'h3)
			begin
				`CHK("select", 2'h3, {SERIAL_BOOT_SLAVE_SELECT, FLAG_PIN_TWO_TAKEN})
				`CHK("cmd", 24'h030000, {SPI_CMD, SPI_ADDR})
				`CHK("abits", m[0] ? 5'h10 : 5'h0C, SPI_ADDR_BITS)
				`CHK("spi cfg", 14'h1E71, {SERIAL_BAUD_DIVISOR, SPI_PHASE, SPI_POLARITY, SPI_WORD, SPI_MSB})
			end
			@(negedge CLK);
			{PORT_SELECT_STRAP, BOOT_STRAP_HIGH, BOOT_STRAP_LOW} = ~m;
			repeat (6) @(negedge CLK);
			`CHK("held", m, BOOT_MODE)
		end
	endtask

	// core stays held until the host clears the semaphore late
	task automatic host_boot();
		rst(3'h2);
		repeat (4) @(negedge CLK);
		`CHK("hold", 2'h2, {CORE_HOLD, VECTORS_PAGE0})
		host_en = 1'b1;
		`WAITFOR(CORE_HOLD, 1'b0)
		@(negedge CLK);
		`CHK("vectors", 1'b1, VECTORS_PAGE0)
		`CHK("start", 24'h000000, FETCH_ADDR)
		host_en = 1'b0;
	endtask

	// fill characters stop for good once the first block starts
	task automatic uart_boot();
		rst(3'h5);
		`CHK("fill", 1'b1, UART_TX_REQ)
		uart_en = 1'b1;
		`WAITFOR(UART_TX_REQ, 1'b0)
		repeat (20) @(negedge CLK);
		`CHK("fill stop", 1'b0, UART_TX_REQ)
		uart_en = 1'b0;
	endtask

	// a pending bus request delays the branch, then load done releases the core
	task automatic bus_hold();
		BUS_REQUEST = 1'b1;
		rst(3'h7);
		`CHK("no branch", 2'h0, {LOAD_ACTIVE, SERIAL_BOOT_SLAVE_SELECT})
		`CHK("rom", 24'hFF0000, FETCH_ADDR)
		BUS_REQUEST = 1'b0;
		`WAITFOR(LOAD_ACTIVE, 1'b1)
		LOAD_DONE = 1'b1;
		@(negedge CLK);
		LOAD_DONE = 1'b0;
		`WAITFOR(CORE_HOLD, 1'b0)
		`CHK("done", 2'h0, {LOAD_ACTIVE, SERIAL_BOOT_SLAVE_SELECT})
	endtask

	// byte stream back to back, then a gapped 16-bit stream
	task automatic streams();
		stream_en = 1'b1;
		rst(3'h4);
		repeat (10) @(negedge CLK);
		`CHK("cnt8", 2, wcnt)
		`CHK("w8a", 24'hA0A1A2, words[0])
		`CHK("w8b", 24'hA3A4A5, words[1])
		slow = 1'b1;
		EXT_WIDE = 1'b1;
		rst(3'h0);
		repeat (10) @(negedge CLK);
		`CHK("cnt16", 3, wcnt)
		`CHK("w16a", 24'hA1C0A0, words[0])
		`CHK("w16c", 24'hA5C4A4, words[2])
		stream_en = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{RESETN, BUS_REQUEST, LOAD_DONE, EXT_WIDE, host_en, uart_en, stream_en, slow} = 8'h00;
		{PORT_SELECT_STRAP, BOOT_STRAP_HIGH, BOOT_STRAP_LOW, RESET_CONFIG} = 6'h00;
		err_count = 0;
		tests_run = 0;
		all_modes();
		host_boot();
		uart_boot();
		bus_hold();
		streams();
		conclude();
	end
endmodule
